// ---- pkg/accp_pkg.sv ----
// Constants, types and helpers for the ASCII command-channel parser
// Notes on behaviour
// R1: Request holds command, group, item, optional value, then the frame terminator.
// R2: Requests are ASCII; command, group and item compare ignoring letter case.
// R3: Recognised command verbs are get, set, do, login and logout.
// R4: Terminator selectable: comma, colon, semicolon, CR, CR LF, LF CR, ETX.
// R5: Interpretation starts only after the whole selected terminator has arrived.
// R6: Every response frame ends with the same selected terminator.
// R7: No response is sent unless a valid terminator was received.
// R8: A terminator-only frame returns the command-missing error at once.
// R9: The requester waits for the response before sending the next request.
// R10: By default string arguments sit in double quotes, quoted text kept whole.
// R11: Backslash escapes quote or backslash inside strings; parser drops the backslash.
// R12: With string delimiter None, strings are taken without quotes.
// R13: The value field is used only by set commands.
// R14: Get commands need no item field.
// R15: Serial receiver flags parity, break and framing errors for the user.
// R16: Received and sent bytes are kept apart so both counts can be checked.
// R17: Error counter increments once for each error response or dropped response.
// R18: Flag stall when bytes stop before a terminator or the client stops reading.
// R19: First response is OK, or ERROR with five-digit code and identifier.
// R20: Get gives status frame plus value frame; set and do give status only.
// R21: Spaces outside quotes separate command, group, item and value.
// R22: Unrecognised requests answer ERROR instead of being silently dropped.
package accp_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_BAUD   = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_RXCNT  = 8'h0C;
  localparam logic [7:0] A_TXCNT  = 8'h10;
  localparam logic [7:0] A_ERRCNT = 8'h14;
  localparam logic [7:0] A_REQ    = 8'h18;
  localparam logic [7:0] A_GROUP  = 8'h1C;
  localparam logic [7:0] A_ITEM   = 8'h20;
  localparam logic [7:0] A_VALUE  = 8'h24;
  localparam logic [7:0] A_REPLY  = 8'h28;
  localparam int CTRL_TERM = 0;
  localparam int CTRL_NOQ  = 3;
  localparam int CTRL_ETH  = 4;
  localparam int CTRL_PEN  = 5;
  localparam int CTRL_PODD = 6;
  localparam int CTRL_RLEN = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_077F;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0004;
  localparam logic [15:0] BAUD_RST  = 16'h0364;
  localparam int ST_PERR  = 0;
  localparam int ST_BRK   = 1;
  localparam int ST_FERR  = 2;
  localparam int ST_STALL = 3;
  // ********************
  // Characters, terminators, verbs
  // ********************
  localparam logic [2:0] TERM_COMMA = 3'h0;
  localparam logic [2:0] TERM_COLON = 3'h1;
  localparam logic [2:0] TERM_SEMI  = 3'h2;
  localparam logic [2:0] TERM_CR    = 3'h3;
  localparam logic [2:0] TERM_CRLF  = 3'h4;
  localparam logic [2:0] TERM_LFCR  = 3'h5;
  localparam logic [2:0] TERM_ETX   = 3'h6;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_ETX   = 8'h03;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_BSL   = 8'h5C;
  localparam logic [2:0] VERB_NONE   = 3'h0;
  localparam logic [2:0] VERB_GET    = 3'h1;
  localparam logic [2:0] VERB_SET    = 3'h2;
  localparam logic [2:0] VERB_DO     = 3'h3;
  localparam logic [2:0] VERB_LOGIN  = 3'h4;
  localparam logic [2:0] VERB_LOGOUT = 3'h5;
  // ********************
  // Status messages and timing
  // ********************
  localparam int MSG_W = 272;
  localparam logic [2:0] MSG_OK   = 3'h0;
  localparam logic [2:0] MSG_MISS = 3'h1;
  localparam logic [2:0] MSG_NREC = 3'h2;
  localparam logic [2:0] MSG_GRP  = 3'h3;
  localparam logic [2:0] MSG_VAL  = 3'h4;
  localparam logic [MSG_W-1:0] S_OK   = "OK";
  localparam logic [MSG_W-1:0] S_MISS = "ERROR 10000_COMMAND_MISSING";
  localparam logic [MSG_W-1:0] S_NREC = "ERROR 10001_COMMAND_NOT_RECOGNIZED";
  localparam logic [MSG_W-1:0] S_GRP  = "ERROR 10002_GROUP_MISSING";
  localparam logic [MSG_W-1:0] S_VAL  = "ERROR 10003_VALUE_MISSING";
  localparam int CLK_MHZ       = 100;
  localparam int STALL_TIME_US = 100;
  localparam int STALL_CYC_DEF = STALL_TIME_US * CLK_MHZ;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_MSG   = 5'h02,
    TX_TERM  = 5'h04,
    TX_REPLY = 5'h08,
    TX_TERM2 = 5'h10
  } accp_tx_st_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       perr;
    logic       brk;
    logic       ferr;
  } accp_rx_evt_t;

  function automatic logic [5:0] accp_msg_len(input logic [2:0] s);
    case (s)
      MSG_MISS: return 6'h1B;
      MSG_NREC: return 6'h22;
      MSG_GRP:  return 6'h19;
      MSG_VAL:  return 6'h19;
      default:  return 6'h02;
    endcase
  endfunction

  function automatic logic [7:0] accp_msg_char(input logic [2:0] s, input logic [5:0] i);
    logic [MSG_W-1:0] m;
    logic [5:0]       n;
    n = accp_msg_len(s);
    case (s)
      MSG_MISS: m = S_MISS;
      MSG_NREC: m = S_NREC;
      MSG_GRP:  m = S_GRP;
      MSG_VAL:  m = S_VAL;
      default:  m = S_OK;
    endcase
    return m[{n - 6'h01 - i, 3'h0} +: 8];
  endfunction
endpackage

// ---- src/accp_parser.sv ----
// ASCII command-channel parser with AHB-Lite register slave
`timescale 1ns/1ps
module accp_parser import accp_pkg::*; #(
  parameter int STALL_CYC = STALL_CYC_DEF
) (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_rxd,
  input  wire logic        i_eth_valid,
  input  wire logic [7:0]  i_eth_data,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_req_strobe,
  output logic [2:0]       o_req_verb
);
  if (STALL_CYC < 2) begin : g_bad_stall
    $error("STALL_CYC too small");
  end
  localparam int SW = $clog2(STALL_CYC + 1);

  // ********************
  // Bus slave
  // ********************
  logic        wr_pend_reg;
  logic [7:0]  wa_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic [3:0]  stat_reg;
  logic [31:0] rxcnt_reg;
  logic [31:0] txcnt_reg;
  logic [31:0] errcnt_reg;
  logic [31:0] reply_reg;
  logic [31:0] req_reg;
  logic [31:0] grp_reg;
  logic [31:0] item_reg;
  logic [31:0] val_reg;
  accp_tx_st_t tx_st_reg;
  logic        in_frame;

  wire aphase  = i_hsel & i_hready & i_htrans[1];
  wire we_ctrl = wr_pend_reg & (wa_reg == A_CTRL);
  wire we_baud = wr_pend_reg & (wa_reg == A_BAUD);
  wire we_stat = wr_pend_reg & (wa_reg == A_STAT);
  wire we_rxc  = wr_pend_reg & (wa_reg == A_RXCNT);
  wire we_txc  = wr_pend_reg & (wa_reg == A_TXCNT);
  wire we_err  = wr_pend_reg & (wa_reg == A_ERRCNT);
  wire we_rep  = wr_pend_reg & (wa_reg == A_REPLY);
  wire [31:0] stat_rd = {26'h0, in_frame, ~tx_st_reg[0], stat_reg};
  wire [7:0]  ra = i_haddr[7:0];
  wire [31:0] rd_mux = (ra == A_CTRL)   ? ctrl_reg :
                       (ra == A_BAUD)   ? {16'h0, baud_reg} :
                       (ra == A_STAT)   ? stat_rd :
                       (ra == A_RXCNT)  ? rxcnt_reg :
                       (ra == A_TXCNT)  ? txcnt_reg :
                       (ra == A_ERRCNT) ? errcnt_reg :
                       (ra == A_REQ)    ? req_reg :
                       (ra == A_GROUP)  ? grp_reg :
                       (ra == A_ITEM)   ? item_reg :
                       (ra == A_VALUE)  ? val_reg :
                       (ra == A_REPLY)  ? reply_reg : 32'h0;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      wr_pend_reg <= 1'b0;
      wa_reg      <= 8'h00;
      rdata_reg   <= 32'h0;
    end else begin
      wr_pend_reg <= aphase & i_hwrite;
      wa_reg      <= ra;
      if (aphase & ~i_hwrite) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ctrl_reg  <= CTRL_RST;
      baud_reg  <= BAUD_RST;
      reply_reg <= 32'h0;
    end else begin
      if (we_ctrl) ctrl_reg <= i_hwdata & CTRL_MASK;
      if (we_baud) baud_reg <= i_hwdata[15:0];
      if (we_rep) reply_reg <= i_hwdata;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_reg;

  // ********************
  // Byte sources
  // ********************
  accp_rx_evt_t u_evt;
  accp_uart_rx #(.DIV_W(16)) u_rx (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_rxd     (i_rxd),
    .i_div     (baud_reg),
    .i_par_en  (ctrl_reg[CTRL_PEN]),
    .i_par_odd (ctrl_reg[CTRL_PODD]),
    .o_evt     (u_evt)
  );

  wire       src_eth = ctrl_reg[CTRL_ETH];
  wire       bv      = src_eth ? i_eth_valid : u_evt.valid;
  wire [7:0] b       = src_eth ? i_eth_data : u_evt.data;
  wire [2:0] tsel    = ctrl_reg[CTRL_TERM +: 3];
  wire       q_on    = ~ctrl_reg[CTRL_NOQ]; // R10 R12
  wire [7:0] t0 = (tsel == TERM_COMMA) ? CH_COMMA : (tsel == TERM_COLON) ? CH_COLON :
                  (tsel == TERM_SEMI) ? CH_SEMI : (tsel == TERM_LFCR) ? CH_LF :
                  (tsel == TERM_ETX) ? CH_ETX : CH_CR; // R4
  wire [7:0] t1 = (tsel == TERM_LFCR) ? CH_CR : CH_LF;
  wire       two = (tsel == TERM_CRLF) | (tsel == TERM_LFCR);
  wire [5:0] tlen = two ? 6'h02 : 6'h01;

  // ********************
  // Frame scanner
  // ********************
  logic       pend_reg;
  logic       inq_reg;
  logic       esc_reg;
  logic       fst_reg;
  logic [1:0] fld_reg;
  // Terminators count only outside quotes, so quoted text may hold them
  wire frame_end  = bv & ~inq_reg & (two ? (pend_reg & (b == t1)) : (b == t0)); // R5
  wire start_pend = bv & ~inq_reg & two & (b == t0);
  wire proc       = bv & ~frame_end & ~start_pend;
  wire is_sp      = (b == CH_SP);
  wire is_q       = q_on & (b == CH_QUOTE);
  wire app_en = proc & (inq_reg ? (esc_reg | ((b != CH_BSL) & (b != CH_QUOTE))) :
                        is_sp ? (fst_reg & (fld_reg == 2'h3)) : ~is_q); // R11
  wire upper  = (b >= 8'h41) & (b <= 8'h5A);
  wire [7:0] ch = (upper & (fld_reg != 2'h3)) ? (b | 8'h20) : b; // R2
  assign in_frame = fst_reg | (fld_reg != 2'h0) | inq_reg | pend_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pend_reg <= 1'b0;
    end else if (bv) begin
      pend_reg <= start_pend;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst || frame_end) begin
      inq_reg <= 1'b0;
      esc_reg <= 1'b0;
      fst_reg <= 1'b0;
      fld_reg <= 2'h0;
    end else if (proc) begin
      if (inq_reg) begin
        if (esc_reg) esc_reg <= 1'b0;
        else if (b == CH_BSL) esc_reg <= 1'b1; // R11
        else if (b == CH_QUOTE) inq_reg <= 1'b0;
      end else if (is_sp) begin
        if (fst_reg && fld_reg != 2'h3) begin
          fld_reg <= fld_reg + 2'h1; // R21 R1
          fst_reg <= 1'b0;
        end
      end else begin
        fst_reg <= 1'b1;
        if (is_q) inq_reg <= 1'b1; // R10
      end
    end
  end

  for (genvar f = 0; f < 4; f++) begin : g_fld
    localparam logic [7:0] LIM = (f == 0) ? 8'h06 : 8'h04;
    logic [47:0] w_reg;
    logic [7:0]  len_reg;
    always_ff @(posedge i_mclk) begin
      if (!i_nrst || frame_end) begin
        w_reg   <= 48'h0;
        len_reg <= 8'h00;
      end else if (app_en && fld_reg == 2'(f)) begin
        if (len_reg < LIM) w_reg <= {w_reg[39:0], ch};
        if (len_reg != 8'hFF) len_reg <= len_reg + 8'h01;
      end
    end
  end

  // ********************
  // Request decode
  // ********************
  wire [47:0] w0 = g_fld[0].w_reg;
  wire [7:0]  l0 = g_fld[0].len_reg;
  wire [2:0] verb = (l0 == 8'h03 && w0[23:0] == "get") ? VERB_GET :
                    (l0 == 8'h03 && w0[23:0] == "set") ? VERB_SET :
                    (l0 == 8'h02 && w0[15:0] == "do") ? VERB_DO :
                    (l0 == 8'h05 && w0[39:0] == "login") ? VERB_LOGIN :
                    (l0 == 8'h06 && w0 == "logout") ? VERB_LOGOUT : VERB_NONE; // R3
  wire need_grp = (verb == VERB_GET) | (verb == VERB_SET) | (verb == VERB_DO); // R14
  wire [2:0] msg_w = (l0 == 8'h00) ? MSG_MISS : // R8
                     (verb == VERB_NONE) ? MSG_NREC : // R22
                     (need_grp && g_fld[1].len_reg == 8'h00) ? MSG_GRP :
                     (verb == VERB_SET && g_fld[3].len_reg == 8'h00) ? MSG_VAL : MSG_OK; // R13
  wire acc_fr = frame_end & tx_st_reg[0];
  // A request that lands while the previous answer is still going out is lost
  wire drop   = frame_end & ~tx_st_reg[0]; // R9

  logic [2:0] msg_sel_reg;
  logic       get_pend_reg;
  logic       strobe_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      msg_sel_reg  <= MSG_OK;
      get_pend_reg <= 1'b0;
      strobe_reg   <= 1'b0;
      req_reg      <= 32'h0;
      grp_reg      <= 32'h0;
      item_reg     <= 32'h0;
      val_reg      <= 32'h0;
    end else begin
      strobe_reg <= acc_fr & (msg_w == MSG_OK);
      if (acc_fr) begin
        msg_sel_reg  <= msg_w;
        get_pend_reg <= (verb == VERB_GET) & (msg_w == MSG_OK); // R20
        req_reg  <= {g_fld[3].len_reg, g_fld[2].len_reg, g_fld[1].len_reg, 5'h00, verb};
        grp_reg  <= g_fld[1].w_reg[31:0];
        item_reg <= g_fld[2].w_reg[31:0];
        val_reg  <= g_fld[3].w_reg[31:0];
      end
    end
  end
  assign o_req_strobe = strobe_reg;
  assign o_req_verb   = req_reg[2:0];

  // ********************
  // Response sender
  // ********************
  logic [5:0]  idx_reg;
  logic [7:0]  txb_reg;
  accp_tx_st_t st_n;
  logic [5:0]  idx_n;
  wire [2:0] sel_n = acc_fr ? msg_w : msg_sel_reg;
  wire [5:0] mlen  = accp_msg_len(msg_sel_reg);
  wire [2:0] rl    = ctrl_reg[CTRL_RLEN +: 3];
  wire [5:0] rlen  = (rl > 3'h4) ? 6'h04 : {3'h0, rl};
  wire tx_acc = ~tx_st_reg[0] & i_tx_ready;
  wire t_last = (idx_reg == tlen - 6'h01);

  always_comb begin
    st_n  = tx_st_reg;
    idx_n = idx_reg;
    case (tx_st_reg)
      TX_IDLE: if (acc_fr) begin
        st_n  = TX_MSG; // R7 R19
        idx_n = 6'h00;
      end
      TX_MSG: if (tx_acc) begin
        idx_n = (idx_reg == mlen - 6'h01) ? 6'h00 : idx_reg + 6'h01;
        if (idx_reg == mlen - 6'h01) st_n = TX_TERM;
      end
      TX_TERM: if (tx_acc) begin
        idx_n = t_last ? 6'h00 : idx_reg + 6'h01;
        if (t_last) st_n = !get_pend_reg ? TX_IDLE : (rlen == 6'h00) ? TX_TERM2 : TX_REPLY; // R20
      end
      TX_REPLY: if (tx_acc) begin
        idx_n = (idx_reg == rlen - 6'h01) ? 6'h00 : idx_reg + 6'h01;
        if (idx_reg == rlen - 6'h01) st_n = TX_TERM2;
      end
      TX_TERM2: if (tx_acc) begin
        idx_n = t_last ? 6'h00 : idx_reg + 6'h01;
        if (t_last) st_n = TX_IDLE;
      end
      default: st_n = TX_IDLE;
    endcase
  end

  wire [7:0] byte_n = (st_n == TX_MSG) ? accp_msg_char(sel_n, idx_n) :
                      (st_n == TX_REPLY) ? reply_reg[{~idx_n[1:0], 3'h0} +: 8] :
                      (idx_n == 6'h00) ? t0 : t1; // R6

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      tx_st_reg <= TX_IDLE;
      idx_reg   <= 6'h00;
      txb_reg   <= 8'h00;
    end else begin
      tx_st_reg <= st_n;
      idx_reg   <= idx_n;
      txb_reg   <= byte_n;
    end
  end
  assign o_tx_valid = ~tx_st_reg[0];
  assign o_tx_data  = txb_reg;

  // ********************
  // Counters, stall and port errors
  // ********************
  logic [SW-1:0] rx_wait_reg;
  logic [SW-1:0] tx_wait_reg;
  wire rx_stall = in_frame & ~bv & (rx_wait_reg == SW'(STALL_CYC - 1)); // R18
  wire tx_stall = o_tx_valid & ~i_tx_ready & (tx_wait_reg == SW'(STALL_CYC - 1));
  wire err_evt  = (acc_fr & (msg_w != MSG_OK)) | drop; // R17
  wire [3:0] st_set = {rx_stall | tx_stall,
                       u_evt.valid & u_evt.ferr,
                       u_evt.valid & u_evt.brk,
                       u_evt.valid & u_evt.perr}; // R15

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      rx_wait_reg <= '0;
      tx_wait_reg <= '0;
      stat_reg    <= 4'h0;
      rxcnt_reg   <= 32'h0;
      txcnt_reg   <= 32'h0;
      errcnt_reg  <= 32'h0;
    end else begin
      rx_wait_reg <= (!in_frame || bv) ? '0 :
                     (rx_wait_reg == SW'(STALL_CYC)) ? rx_wait_reg : rx_wait_reg + 1'b1;
      tx_wait_reg <= (!o_tx_valid || i_tx_ready) ? '0 :
                     (tx_wait_reg == SW'(STALL_CYC)) ? tx_wait_reg : tx_wait_reg + 1'b1;
      // New events win over a software clear in the same cycle
      stat_reg   <= (stat_reg & ~(we_stat ? i_hwdata[3:0] : 4'h0)) | st_set;
      rxcnt_reg  <= (we_rxc ? 32'h0 : rxcnt_reg) + {31'h0, bv}; // R16
      txcnt_reg  <= (we_txc ? 32'h0 : txcnt_reg) + {31'h0, tx_acc}; // R16
      errcnt_reg <= (we_err ? 32'h0 : errcnt_reg) + {31'h0, err_evt}; // R17
    end
  end

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_no_eof_quiet: assert property (tx_st_reg == TX_IDLE && !frame_end |=> !o_tx_valid) // R7
    else $error("response started without terminator");
  a_empty_missing: assert property (acc_fr && l0 == 8'h00 |=> // R8
      msg_sel_reg == MSG_MISS && o_tx_valid && o_tx_data == 8'h45)
    else $error("empty frame did not answer missing command");
  a_resp_term_end: assert property (tx_st_reg == TX_TERM && tx_acc && t_last |-> // R6
      o_tx_data == (two ? t1 : t0))
    else $error("status frame not closed by terminator");
  a_get_second: assert property (tx_st_reg == TX_TERM && tx_acc && t_last |=> // R20
      (get_pend_reg ? !tx_st_reg[0] : tx_st_reg == TX_IDLE))
    else $error("get reply frame count wrong");
  a_err_count_up: assert property (err_evt && !we_err |=> errcnt_reg == $past(errcnt_reg) + 1) // R17
    else $error("error counter did not step");
  a_rx_count_up: assert property (bv && !we_rxc |=> rxcnt_reg == $past(rxcnt_reg) + 1) // R16
    else $error("received byte not counted");
  a_stall_flag: assert property (rx_stall |=> stat_reg[ST_STALL]) // R18
    else $error("stall not flagged");
  a_parity_flag: assert property (u_evt.valid && u_evt.perr |=> stat_reg[ST_PERR]) // R15
    else $error("parity error not flagged");
  a_fold_case: assert property (app_en && fld_reg == 2'h0 && l0 < 8'h06 && upper |=> // R2
      w0[7:0] == ($past(b) | 8'h20))
    else $error("command letter not folded");
  a_escape_keep: assert property (proc && inq_reg && esc_reg && fld_reg == 2'h3 && // R11
      g_fld[3].len_reg < 8'h04 |=> g_fld[3].w_reg[7:0] == $past(b) && inq_reg)
    else $error("escaped character lost");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)) // R6
    else $error("tx byte changed while stalled");
  a_unknown_err: assert property (acc_fr && l0 != 8'h00 && verb == VERB_NONE |=> // R22
      msg_sel_reg == MSG_NREC && o_tx_valid)
    else $error("unknown verb not answered");
endmodule

// ---- src/accp_uart_rx.sv ----
// Serial byte receiver with parity, break and framing checks
`timescale 1ns/1ps
module accp_uart_rx import accp_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic             i_rxd,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_par_en,
  input  wire logic             i_par_odd,
  output accp_rx_evt_t          o_evt
);
  if (DIV_W < 4) begin : g_bad_w
    $error("DIV_W too small");
  end

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } accp_rx_st_t;

  logic             s1_reg;
  logic             s2_reg;
  accp_rx_st_t      st_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic [2:0]       bit_reg;
  logic [7:0]       sh_reg;
  logic             par_reg;
  accp_rx_evt_t     evt_reg;
  wire              tick = (cnt_reg == '0);
  // Break is a whole character of zeros with the stop bit low as well
  wire              brk  = (sh_reg == 8'h00) & ~s2_reg & ~(i_par_en & par_reg);
  wire              perr = i_par_en & (^{sh_reg, par_reg} ^ i_par_odd);

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= i_rxd;
      s2_reg <= s1_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_reg  <= RX_IDLE;
      cnt_reg <= '0;
      bit_reg <= 3'h0;
      sh_reg  <= 8'h00;
      par_reg <= 1'b0;
      evt_reg <= '0;
    end else begin
      evt_reg.valid <= 1'b0;
      cnt_reg       <= tick ? i_div - 1'b1 : cnt_reg - 1'b1;
      case (st_reg)
        RX_IDLE: begin
          cnt_reg <= i_div >> 1;
          if (!s2_reg) begin
            st_reg <= RX_START;
          end
        end
        RX_START: if (tick) begin
          st_reg  <= s2_reg ? RX_IDLE : RX_DATA;
          bit_reg <= 3'h0;
        end
        RX_DATA: if (tick) begin
          sh_reg  <= {s2_reg, sh_reg[7:1]};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            st_reg <= i_par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (tick) begin
          par_reg <= s2_reg;
          st_reg  <= RX_STOP;
        end
        RX_STOP: if (tick) begin
          evt_reg <= '{valid: 1'b1, data: sh_reg, perr: perr, brk: brk, ferr: ~s2_reg}; // R15
          st_reg  <= RX_IDLE;
        end
        default: st_reg <= RX_IDLE;
      endcase
    end
  end

  assign o_evt = evt_reg;
endmodule

// ---- verif/accp_host.sv ----
// Control device model: sends request bytes, sinks response bytes
`timescale 1ns/1ps
module accp_host (
  input  wire logic       i_mclk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_eth_valid,
  output logic [7:0]      o_eth_data,
  output logic            o_tx_ready
);
  string  rx_s = "";
  integer seed = 32'hC12E4216;
  int     nsent = 0, nrecv = 0;
  initial begin
    o_eth_valid = 1'b0;
    o_eth_data  = 8'h00;
    o_tx_ready  = 1'b0;
  end
  // Random ready: a slow reader must not lose bytes
  always @(posedge i_mclk) begin
    if (i_tx_valid && o_tx_ready) begin
      rx_s = {rx_s, $sformatf("%c", i_tx_data)};
      nrecv++;
    end
    o_tx_ready <= seed[0];
    seed = $random(seed);
  end
  // Whole frame then released; the caller waits for the reply first
  task automatic send(input string s);
    nsent += s.len();
    for (int i = 0; i < s.len(); i++) begin
      @(posedge i_mclk);
      o_eth_valid <= 1'b1;
      o_eth_data  <= s[i];
    end
    @(posedge i_mclk);
    o_eth_valid <= 1'b0;
    o_eth_data  <= ~o_eth_data;
  endtask
endmodule

// ---- verif/tb_ascii_command_channel_parser.sv ----
// Self-checking bench for the command-channel parser
`timescale 1ns/1ps
module tb_ascii_command_channel_parser;
  import accp_pkg::*;
  logic        i_mclk = 1'b0, i_nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic        txv, eth_v, rdy, strb, rxd = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  verb, ev;
  logic [7:0]  txd, eth_d;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  int          bad_count = 0, tests_run = 0, errs = 0, nstrb = 0;
  string       rq[10] = '{"", "DO X", "Get Info", "set g i", "set g i \"a\\\"b\\\\c\"",
                          "login", "logout", "foo x", "do", "do sys reboot"};
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (strb === 1'b1) nstrb++;
  accp_parser #(.STALL_CYC(8)) i_accp_parser (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_rxd(rxd), .i_eth_valid(eth_v), .i_eth_data(eth_d),
    .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(rdy), .o_req_strobe(strb),
    .o_req_verb(verb));
  accp_host i_accp_host (.i_mclk(i_mclk), .i_tx_valid(txv), .i_tx_data(txd),
    .o_eth_valid(eth_v), .o_eth_data(eth_d), .o_tx_ready(rdy));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chks(input string n, input string e, input string g);
    tests_run++;
    if (g != e) begin
      bad_count++;
      $display("wrong value %s expected %s seen %s", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge i_mclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_mclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  function automatic string model(input string r, input string t);
    string w[$];
    string c;
    c = "";
    ev = VERB_NONE;
    for (int i = 0; i < r.len(); i++) begin
      if (r[i] != " ") c = $sformatf("%s%c", c, r[i]);
      else if (c != "") begin
        w.push_back(c);
        c = "";
      end
    end
    if (c != "") w.push_back(c);
    if (w.size() == 0) return {"ERROR 10000_COMMAND_MISSING", t};
    c = w[0].tolower();
    ev = (c == "get") ? VERB_GET : (c == "set") ? VERB_SET : (c == "do") ? VERB_DO :
         (c == "login") ? VERB_LOGIN : (c == "logout") ? VERB_LOGOUT : VERB_NONE;
    if (!(c inside {"get", "set", "do", "login", "logout"}))
      return {"ERROR 10001_COMMAND_NOT_RECOGNIZED", t};
    if (c != "login" && c != "logout" && w.size() < 2) return {"ERROR 10002_GROUP_MISSING", t};
    if (c == "set" && w.size() < 4) return {"ERROR 10003_VALUE_MISSING", t};
    return (c == "get") ? {"OK", t, t} : {"OK", t};
  endfunction
  task automatic run(input string r, input string s, input string t);
    string e;
    int    n0;
    e = model(r, t);
    if (e[0] == "E") errs++;
    i_accp_host.rx_s = "";
    n0 = nstrb;
    i_accp_host.send({s, t});
    repeat (300) @(posedge i_mclk);
    chks(r, e, i_accp_host.rx_s);
    chk("verb", {29'h0, ev}, {29'h0, verb});
    chk("strobe", (e[0] == "E") ? 32'h0 : 32'h1, nstrb - n0);
    $display("done [%s]", r);
  endtask
  // Serial frame: start, eight data bits, parity, stop; 16 clocks a bit
  task automatic ser(input logic [10:0] f, input logic [2:0] e);
    ahb(1'b1, A_STAT, 32'hF);
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge i_mclk);
    end
    rxd <= 1'b1;
    repeat (20) @(posedge i_mclk);
    ahb(1'b0, A_STAT, 32'h0);
    chk("port errors", {29'h0, e}, {29'h0, q[2:0]});
    $display("done serial");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    ahb(1'b0, A_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RST, q);
    ahb(1'b0, 8'h2C, 32'h0);
    chk("unmapped", 32'h0, q);
    ahb(1'b1, A_CTRL, 32'h14);
    foreach (rq[i]) run(rq[i], rq[i], "\r\n");
    ahb(1'b1, A_CTRL, 32'h12);
    run("set g i \"x;y\"", "set g i \"x;y\"", ";");
    ahb(1'b1, A_STAT, 32'hF);
    i_accp_host.rx_s = "";
    i_accp_host.send("do x");
    repeat (40) @(posedge i_mclk);
    chks("no reply", "", i_accp_host.rx_s);
    ahb(1'b0, A_STAT, 32'h0);
    chk("stall", 32'h1, {31'h0, q[ST_STALL]});
    run("do x", "", ";");
    ahb(1'b1, A_CTRL, 32'h1A);
    run("set g i abc", "set g i abc", ";");
    ahb(1'b0, A_ERRCNT, 32'h0);
    chk("errcnt", errs, q);
    ahb(1'b0, A_RXCNT, 32'h0);
    chk("rxcnt", i_accp_host.nsent, q);
    ahb(1'b0, A_TXCNT, 32'h0);
    chk("txcnt", i_accp_host.nrecv, q);
    ahb(1'b1, A_BAUD, 32'h10);
    ahb(1'b1, A_CTRL, 32'h23);
    ser(11'h682, 3'h1);
    ser(11'h000, 3'h6);
    end_of_test();
  end
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
endmodule
